// ===== ltbct_pkg.sv
`default_nettype none
package ltbct_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] LTBCT_IDX_CSR2   = 6'h08;
	localparam logic [5:0] LTBCT_IDX_RELOAD = 6'h09;
	localparam logic [5:0] LTBCT_IDX_CNT2   = 6'h0a;
	localparam logic [5:0] LTBCT_IDX_CSR1   = 6'h0b;
	localparam logic [5:0] LTBCT_IDX_CAPT   = 6'h0c;

	// field positions, second control/status register
	localparam int LTBCT_CSR2_TIMEBASE_TWO_FLAG  = 0;
	localparam int LTBCT_CSR2_TIMEBASE_TWO_IRQ_ENABLE = 1;

	// field positions, first control/status register
	localparam int LTBCT_CSR1_TIMEBASE_ONE_FLAG  = 3;
	localparam int LTBCT_CSR1_TIMEBASE_ONE_IRQ_ENABLE = 4;
	localparam int LTBCT_CSR1_PSEL  = 5;
	localparam int LTBCT_CSR1_ICF   = 6;
	localparam int LTBCT_CSR1_CAPTURE_IRQ_ENABLE  = 7;

	// values after reset
	localparam logic [7:0] LTBCT_RST_RELOAD = 8'h00;
	localparam logic [7:0] LTBCT_RST_CNT1   = 8'h00;
	localparam logic [7:0] LTBCT_RST_CAPT   = 8'h00;
	localparam logic       LTBCT_RST_ICF    = 1'b0;

	// counting constants; divider in oscillator periods, tops and length in steps
	localparam int unsigned LTBCT_OSC_DIV  = 32;
	localparam logic [7:0]  LTBCT_CNT1_TOP = 8'hf9;
	localparam logic [7:0]  LTBCT_CNT2_TOP = 8'hff;
	localparam int unsigned LTBCT_CNT1_LEN =
		32'(LTBCT_CNT1_TOP) + 32'd1;
	// one timebase period is this many oscillator periods
	localparam int unsigned LTBCT_TB_SHORT = LTBCT_OSC_DIV * LTBCT_CNT1_LEN;
	localparam int unsigned LTBCT_TB_LONG  = 2 * LTBCT_TB_SHORT;
endpackage
`default_nettype wire

// ===== ltbct_prescale.sv
`timescale 1ns/100ps
`default_nettype none
module ltbct_prescale #(
	parameter int unsigned DIV = ltbct_pkg::LTBCT_OSC_DIV
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// control
	input  wire logic run_i,
	// one-cycle advance strobe
	output logic      tick_o
);
	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} ltbct_pre_s;

	ltbct_pre_s st;
	ltbct_pre_s next_st;

	// a divide by one has no counter to wrap
	initial begin
		if (DIV < 2) begin
			$error("ltbct_prescale: DIV must be at least 2");
		end
	end

	// divider freezes in halt, keeping its phase
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (run_i) begin
			if (st.cnt == LAST) begin
				next_st.cnt = '0;
				next_st.tick = 1'b1;
			end else begin
				next_st.cnt = st.cnt + W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_o = st.tick;
endmodule
`default_nettype wire

// ===== ltbct_timer.sv
// Overview of operation
// - hidden counter one starts at zero, steps every 32 periods, no access
// - counter one wraps from f9 to 00; that wrap is its overflow
// - timebase event every 8000 periods, or 16000 with period_select set
// - timebase one event sets its flag; irq is flag and enable
// - reading first control/status clears timebase one flag; writes cannot change it
// - capture pin edge copies counter one, sets capture flag, irq if enabled
// - reading capture register clears capture flag; writes cannot change it
// - while capture flag is set, pin edges are ignored, value held
// - counter two starts from reload value, steps every 32, readable
// - counter two passing ff reloads from reload register, not zero
// - reload writes anytime; they take effect only at next overflow
// - counter two overflow sets flag; irq if enabled; read clears it
// - counting goes on in slow, wait, active-halt; stops in halt
// - counter two period is 4 us to 1.024 ms in 4 us steps
// - three interrupt requests leave on separate outputs
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ltbct_timer #(
	parameter int unsigned ADR_W = 8
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// wishbone classic slave
	input  wire logic [ADR_W-1:0]  adr_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	input  wire logic              we_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	output logic                   ack_o,
	// power mode and pin
	input  wire logic              halt_i,
	input  wire logic              capture_input_pin_i,
	// interrupt requests, one per vector
	output logic                   timebase_one_irq_o,
	output logic                   timebase_two_irq_o,
	output logic                   capture_irq_o
);
	typedef struct packed {
		// counters and capture
		logic [7:0] cnt1;
		logic       cnt1_half;
		logic [7:0] cnt2;
		logic [7:0] reload_field;
		logic [7:0] captured_field;
		// flags and enables
		logic       timebase_one_flag;
		logic       timebase_two_flag;
		logic       capture_flag;
		logic       timebase_one_irq_enable;
		logic       timebase_two_irq_enable;
		logic       capture_irq_enable;
		logic       period_select;
		// pin synchroniser and edge detector
		logic       pin_meta;
		logic       pin_sync;
		logic       pin_prev;
		logic [1:0] pin_fill;
		// bus answer
		logic       ack;
		logic [7:0] rdata;
	} ltbct_state_s;

	ltbct_state_s st;
	ltbct_state_s next_st;
	logic         tick;
	logic         req;
	logic         rd;
	logic         wr;
	logic [5:0]   idx;
	logic [7:0]   rd_val;
	logic         cnt1_wrap;
	logic         tb1_event;
	logic         tb2_event;
	logic         pin_edge;
	logic         hit_csr1;
	logic         hit_csr2;
	logic         hit_reload;
	logic         hit_capt;

	// per-register strobes
	logic         clr_tb1;
	logic         clr_tb2;
	logic         clr_capt;
	logic         wr_csr1;
	logic         wr_csr2;
	logic         wr_reload;

	// decode reads byte address bits 7:2; a narrower bus could not
	// supply all six of those bits
	initial begin
		if (ADR_W < 8) begin
			$error("ltbct_timer: ADR_W must be at least 8");
		end
	end

	// shared fosc/32 step; halt freezes both counters
	// a step already issued when halt rises still lands: halt is a level
	// sampled like any other input, so one step of latency is accepted
	ltbct_prescale #(
		.DIV    (ltbct_pkg::LTBCT_OSC_DIV)
	) i_ltbct_prescale (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (!halt_i),
		.tick_o (tick)
	);

	// request is taken once; ack drops the cycle after it rose
	assign req = cyc_i && stb_i && !st.ack;
	assign rd  = req && !we_i;
	assign wr  = req && we_i && sel_i[0];
	assign idx = adr_i[7:2];

	// read side effects land at the edge that takes the read
	assign clr_tb1  = rd && hit_csr1;
	assign clr_tb2  = rd && hit_csr2;
	assign clr_capt = rd && hit_capt;
	// writes need byte lane 0, the only lane that holds a register
	assign wr_csr1   = wr && hit_csr1;
	assign wr_csr2   = wr && hit_csr2;
	assign wr_reload = wr && hit_reload;

	// address decode; upper address bits must be zero to hit
	always_comb begin
		hit_csr1 = 1'b0;
		hit_csr2 = 1'b0;
		hit_reload = 1'b0;
		hit_capt = 1'b0;
		rd_val = 8'h00;
		// a shift, not a part-select, so an eight-bit bus still elaborates
		if ((adr_i >> 8) != '0) begin
			rd_val = 8'h00;
		end else if (adr_i[1:0] != 2'h0) begin
			rd_val = 8'h00;
		end else if (idx == ltbct_pkg::LTBCT_IDX_CSR2) begin
			hit_csr2 = 1'b1;
			// upper six bits read as zero
			rd_val[ltbct_pkg::LTBCT_CSR2_TIMEBASE_TWO_FLAG] = st.timebase_two_flag;
			rd_val[ltbct_pkg::LTBCT_CSR2_TIMEBASE_TWO_IRQ_ENABLE] =
				st.timebase_two_irq_enable;
		end else if (idx == ltbct_pkg::LTBCT_IDX_RELOAD) begin
			hit_reload = 1'b1;
			rd_val = st.reload_field;
		end else if (idx == ltbct_pkg::LTBCT_IDX_CNT2) begin
			rd_val = st.cnt2;
		end else if (idx == ltbct_pkg::LTBCT_IDX_CSR1) begin
			hit_csr1 = 1'b1;
			rd_val[ltbct_pkg::LTBCT_CSR1_TIMEBASE_ONE_FLAG] = st.timebase_one_flag;
			rd_val[ltbct_pkg::LTBCT_CSR1_TIMEBASE_ONE_IRQ_ENABLE] =
				st.timebase_one_irq_enable;
			rd_val[ltbct_pkg::LTBCT_CSR1_PSEL] = st.period_select;
			rd_val[ltbct_pkg::LTBCT_CSR1_ICF] = st.capture_flag;
			rd_val[ltbct_pkg::LTBCT_CSR1_CAPTURE_IRQ_ENABLE] = st.capture_irq_enable;
		end else if (idx == ltbct_pkg::LTBCT_IDX_CAPT) begin
			hit_capt = 1'b1;
			rd_val = st.captured_field;
		end else begin
			rd_val = 8'h00; // unmapped: acked, reads zero
		end
	end

	// counter one event terms
	assign cnt1_wrap = tick && (st.cnt1 == ltbct_pkg::LTBCT_CNT1_TOP);
	// long period takes every second wrap
	assign tb1_event = cnt1_wrap && (!st.period_select || st.cnt1_half);
	assign tb2_event = tick && (st.cnt2 == ltbct_pkg::LTBCT_CNT2_TOP);
	// edge seen between second and third flop, never the first; armed
	// only once the chain has refilled after reset
	assign pin_edge = (&st.pin_fill) && (st.pin_sync ^ st.pin_prev);

	// next state
	always_comb begin
		next_st = st;

		// bus answer; read data latched with pre-clear flag values
		next_st.ack = req;
		if (rd) begin
			next_st.rdata = rd_val;
		end

		// pin synchroniser
		next_st.pin_meta = capture_input_pin_i;
		next_st.pin_sync = st.pin_meta;
		next_st.pin_prev = st.pin_sync;
		// a pin idling high would otherwise fake an edge after reset
		if (!(&st.pin_fill)) begin
			next_st.pin_fill = st.pin_fill + 2'h1;
		end

		// counter one: no bus path reaches it
		if (tick) begin
			if (cnt1_wrap) begin
				next_st.cnt1 = 8'h00;
				next_st.cnt1_half = !st.cnt1_half;
			end else begin
				next_st.cnt1 = st.cnt1 + 8'h01;
			end
		end

		// counter two: reload replaces zero at overflow; a reload written
		// in the overflow cycle itself waits for the following overflow
		if (tick) begin
			if (tb2_event) begin
				next_st.cnt2 = st.reload_field;
			end else begin
				next_st.cnt2 = st.cnt2 + 8'h01;
			end
		end

		// control writes; flag bits are not writable
		if (wr_csr1) begin
			next_st.capture_irq_enable =
				dat_i[ltbct_pkg::LTBCT_CSR1_CAPTURE_IRQ_ENABLE];
			next_st.period_select = dat_i[ltbct_pkg::LTBCT_CSR1_PSEL];
			next_st.timebase_one_irq_enable =
				dat_i[ltbct_pkg::LTBCT_CSR1_TIMEBASE_ONE_IRQ_ENABLE];
		end
		if (wr_csr2) begin
			next_st.timebase_two_irq_enable =
				dat_i[ltbct_pkg::LTBCT_CSR2_TIMEBASE_TWO_IRQ_ENABLE];
		end
		// running count untouched; value waits for overflow
		if (wr_reload) begin
			next_st.reload_field = dat_i[7:0];
		end

		// flags: a set in the clearing cycle wins
		// so software never loses an event that it has not yet seen
		next_st.timebase_one_flag = tb1_event ||
			(st.timebase_one_flag && !clr_tb1);
		next_st.timebase_two_flag = tb2_event ||
			(st.timebase_two_flag && !clr_tb2);

		// capture blocked while flag stands, so the value holds
		// an edge in the cycle of a clearing read is dropped: flag stood
		if (pin_edge && !st.capture_flag) begin
			next_st.captured_field = st.cnt1;
			next_st.capture_flag = 1'b1;
		end else if (clr_capt) begin
			next_st.capture_flag = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// counters and capture
			st.cnt1 <= ltbct_pkg::LTBCT_RST_CNT1;
			st.cnt1_half <= 1'b0;
			st.reload_field <= ltbct_pkg::LTBCT_RST_RELOAD;
			// counter two starts from the reset reload value
			st.cnt2 <= ltbct_pkg::LTBCT_RST_RELOAD;
			st.captured_field <= ltbct_pkg::LTBCT_RST_CAPT;

			// flags and enables clear; the capture flag is given a value
			// here, though software still reads the capture register once
			st.timebase_one_flag <= 1'b0;
			st.timebase_two_flag <= 1'b0;
			st.capture_flag <= ltbct_pkg::LTBCT_RST_ICF;
			st.timebase_one_irq_enable <= 1'b0;
			st.timebase_two_irq_enable <= 1'b0;
			st.capture_irq_enable <= 1'b0;
			st.period_select <= 1'b0;

			// pin chain flushed, edge detect disarmed
			st.pin_meta <= 1'b0;
			st.pin_sync <= 1'b0;
			st.pin_prev <= 1'b0;
			st.pin_fill <= 2'h0;

			// no answer pending, read data cleared
			st.ack <= 1'b0;
			st.rdata <= 8'h00;
		end else begin
			st <= next_st;
		end
	end

	// bus outputs
	// every register is one byte, so the upper lanes read zero
	assign ack_o = st.ack;
	assign dat_o = {24'h000000, st.rdata};

	// separate request lines, each flag and its enable
	// a request stays up until its flag is read away or its enable cleared
	assign timebase_one_irq_o =
		st.timebase_one_flag && st.timebase_one_irq_enable;
	assign timebase_two_irq_o =
		st.timebase_two_flag && st.timebase_two_irq_enable;
	assign capture_irq_o =
		st.capture_flag && st.capture_irq_enable;
endmodule
`default_nettype wire

// ===== ltbct_timer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ltbct_timer_chk #(
	parameter int unsigned ADR_W = 8
) (
	// clock, reset, bus
	input wire logic             clk_i,
	input wire logic             rst_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [31:0]      dat_o,
	input wire logic             we_i,
	input wire logic             cyc_i,
	input wire logic             stb_i,
	input wire logic             ack_o,
	// mode, pin, requests
	input wire logic             halt_i,
	input wire logic             capture_input_pin_i,
	input wire logic             timebase_one_irq_o,
	input wire logic             timebase_two_irq_o,
	input wire logic             capture_irq_o
);
	// register byte addresses
	localparam logic [ADR_W-1:0] CSR2 = ADR_W'(8'h20);
	localparam logic [ADR_W-1:0] CSR1 = ADR_W'(8'h2c);
	localparam logic [ADR_W-1:0] CAPT = ADR_W'(8'h30);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// open request, then a single-cycle answer
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_ack;
		ack_o ##1 !ack_o;
	endsequence
	property p_ack;
		s_req |=> s_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack fault");
	property p_dat;
		ack_o |-> dat_o[31:8] == 24'h0;
	endproperty
	a_dat: assert property (p_dat) else $error("upper data set");
	property p_rsv;
		ack_o && !we_i && adr_i == CSR2 |-> dat_o[7:2] == 6'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved set");
	// a request only drops after an access to its register
	property p_tb1;
		$fell(timebase_one_irq_o) |-> $past(cyc_i && stb_i && adr_i == CSR1);
	endproperty
	a_tb1: assert property (p_tb1) else $error("tb1 drop");
	property p_tb2;
		$fell(timebase_two_irq_o) |-> $past(cyc_i && stb_i && adr_i == CSR2);
	endproperty
	a_tb2: assert property (p_tb2) else $error("tb2 drop");
	property p_cap;
		$fell(capture_irq_o) |->
			$past(cyc_i && stb_i && (adr_i == CAPT || adr_i == CSR1));
	endproperty
	a_cap: assert property (p_cap) else $error("cap drop");
	// a capture needs a pin change a few cycles back
	property p_src;
		$rose(capture_irq_o) && !$past(cyc_i && stb_i) |->
			$past(capture_input_pin_i, 2) != $past(capture_input_pin_i, 6);
	endproperty
	a_src: assert property (p_src) else $error("cap no edge");
	// two halted edges leave no room for a new overflow
	property p_halt;
		halt_i && $past(halt_i) && $past(halt_i, 2) && !$past(cyc_i && stb_i)
			|-> !$rose(timebase_one_irq_o) && !$rose(timebase_two_irq_o);
	endproperty
	a_halt: assert property (p_halt) else $error("halt count");
endmodule
`default_nettype wire

// ===== ltbct_timer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ltbct_timer_tb_top;
	logic        clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
	logic        halt_i = 0, capture_input_pin_i = 0, ack_o;
	logic        timebase_one_irq_o, timebase_two_irq_o, capture_irq_o;
	logic [7:0]  adr_i = 8'h0;
	logic [3:0]  sel_i = 4'h1;
	logic [31:0] dat_i = 32'h0, dat_o, rd, v;
	int          miscompares = 0, n_compared = 0;
	time         t0;
	// rows: address, write, write data, expected read
	logic [31:0] rows [16] = '{32'h20000000, 32'h24000000, 32'h28000000,
		32'h30000000, 32'h2c000000, 32'h34000000, 32'h20010200, 32'h20000002,
		32'h2c01ff00, 32'h2c0000b0, 32'h3001ff00, 32'h30000000, 32'h2801ff00,
		32'h2401a500, 32'h240000a5, 32'h2d000000};
	ltbct_timer #(.ADR_W(8)) i_ltbct_timer (.clk_i, .rst_i, .adr_i, .dat_i,
		.dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .halt_i,
		.capture_input_pin_i, .timebase_one_irq_o, .timebase_two_irq_o,
		.capture_irq_o);
	initial forever #4 clk_i = ~clk_i;
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic fail();
		chk(32'h0, 32'h1);
		stop_test();
	endtask
	// one classic cycle; request held until ack is sampled
	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		adr_i <= a;
		we_i <= w;
		dat_i <= {24'h0, d};
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
		if (n >= 20) fail();
	endtask
	// bounded wait for a timebase request
	task automatic wirq(input int k, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((k == 1 ? timebase_one_irq_o : timebase_two_irq_o) !== 1'b1
			&& n < lim);
		if (n >= lim) fail();
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// reset values and access kinds
		foreach (rows[i]) begin
			wb(rows[i][31:24], rows[i][16], rows[i][15:8], rd);
			if (!rows[i][16]) chk(rd, {24'h0, rows[i][7:0]});
		end
		// a write without byte lane 0 is dropped
		sel_i <= 4'h0;
		wb(8'h24, 1'b1, 8'h5a, rd);
		sel_i <= 4'h1;
		wb(8'h24, 1'b0, 8'h00, rd);
		chk(rd, 32'ha5);
		// counter two reload, late reload write
		wb(8'h24, 1'b1, 8'hfe, rd);
		wb(8'h20, 1'b0, 8'h00, rd);
		wirq(2, 10000);
		wb(8'h28, 1'b0, 8'h00, rd);
		chk(rd, 32'hfe);
		wb(8'h24, 1'b1, 8'h10, rd);
		wb(8'h20, 1'b0, 8'h00, rd);
		chk(rd, 32'h03);
		wirq(2, 100);
		wb(8'h28, 1'b0, 8'h00, rd);
		chk(rd, 32'h10);
		wb(8'h20, 1'b0, 8'h00, rd);
		wb(8'h20, 1'b0, 8'h00, rd);
		chk(rd, 32'h02);
		// halt freezes counting, release resumes it
		halt_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		wb(8'h28, 1'b0, 8'h00, v);
		repeat (100) @(posedge clk_i);
		wb(8'h28, 1'b0, 8'h00, rd);
		chk(rd, v);
		halt_i <= 1'b0;
		repeat (100) @(posedge clk_i);
		wb(8'h28, 1'b0, 8'h00, rd);
		chk({31'h0, rd !== v}, 32'h1);
		// timebase one periods, short then long
		wb(8'h2c, 1'b1, 8'h10, rd);
		wb(8'h2c, 1'b0, 8'h00, rd);
		wirq(1, 9000);
		t0 = $time;
		wb(8'h2c, 1'b0, 8'h00, rd);
		wirq(1, 9000);
		chk(32'(($time - t0) / 8), 32'h1f40);
		wb(8'h2c, 1'b1, 8'hb0, rd);
		wb(8'h2c, 1'b0, 8'h00, rd);
		wirq(1, 17000);
		t0 = $time;
		wb(8'h2c, 1'b0, 8'h00, rd);
		wirq(1, 17000);
		chk(32'(($time - t0) / 8), 32'h3e80);
		// counter one is 2 here; a later edge would see 3
		repeat (75) @(posedge clk_i);
		capture_input_pin_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk({31'h0, capture_irq_o}, 32'h1);
		capture_input_pin_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		wb(8'h30, 1'b0, 8'h00, rd);
		chk(rd, 32'h02);
		wb(8'h2c, 1'b0, 8'h00, rd);
		chk(rd, 32'hb8);
		chk({31'h0, capture_irq_o}, 32'h0);
		// mid-run reset returns every register to its reset value
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({29'h0, timebase_one_irq_o, timebase_two_irq_o,
			capture_irq_o}, 32'h0);
		wb(8'h30, 1'b0, 8'h00, rd);
		chk(rd, 32'h00);
		wb(8'h2c, 1'b0, 8'h00, rd);
		chk(rd, 32'h00);
		wb(8'h24, 1'b0, 8'h00, rd);
		chk(rd, 32'h00);
		wb(8'h28, 1'b0, 8'h00, rd);
		chk(rd, 32'h00);
		wb(8'h20, 1'b0, 8'h00, rd);
		chk(rd, 32'h00);
		stop_test();
	end
endmodule
bind ltbct_timer ltbct_timer_chk #(.ADR_W(ADR_W)) i_ltbct_timer_chk (.clk_i,
	.rst_i, .adr_i, .dat_o, .we_i, .cyc_i, .stb_i, .ack_o, .halt_i,
	.capture_input_pin_i, .timebase_one_irq_o, .timebase_two_irq_o,
	.capture_irq_o);
`default_nettype wire
